// ===== common/csm_pkg.sv
package csm_pkg;
  // operating_mode_selector codes
  localparam logic [7:0]  MODE_CSV      = 8'h09;
  localparam logic [7:0]  MODE_CST      = 8'h0A;
  localparam logic [7:0]  MODE_STEP     = 8'hFF;
  localparam logic [7:0]  TIDX_MS       = 8'hFD; // exponent -3
  // ----------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------
  localparam logic [7:0]  A_MODE        = 8'h00;
  localparam logic [7:0]  A_CTRL        = 8'h04;
  localparam logic [7:0]  A_CFG         = 8'h08;
  localparam logic [7:0]  A_PERIOD      = 8'h0C;
  localparam logic [7:0]  A_TVEL        = 8'h10;
  localparam logic [7:0]  A_TTRQ        = 8'h14;
  localparam logic [7:0]  A_MTRQ        = 8'h18;
  localparam logic [7:0]  A_NUM         = 8'h1C;
  localparam logic [7:0]  A_DEN         = 8'h20;
  localparam logic [7:0]  A_FWIN        = 8'h24;
  localparam logic [7:0]  A_FTMO        = 8'h28;
  localparam logic [7:0]  A_STAT        = 8'h2C;
  localparam logic [7:0]  A_POS         = 8'h30;
  localparam logic [7:0]  A_REV         = 8'h34;
  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int          CFG_SUB       = 0;
  localparam int          CFG_CL        = 1;
  localparam int          CFG_PP_LSB    = 8;
  localparam int          SW_SYNC       = 8;
  localparam int          SW_FOLLOW     = 12;
  localparam int          SW_FERR       = 13;
  localparam int          SW_LIM_NEG    = 14;
  localparam int          SW_LIM_POS    = 15;
  localparam int          FRAC          = 16;
  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic [15:0] NUM_RST       = 16'h0080;
  localparam logic [15:0] DEN_RST       = 16'h0001;
  localparam logic [31:0] WFX_RST       = 32'h0080_0000;
  localparam logic [7:0]  PERIOD_RST    = 8'h01;
  localparam logic [7:0]  TIDX_RST      = 8'hFD;
  localparam logic [7:0]  PP_RST        = 8'h01;
  localparam logic [15:0] MTRQ_RST      = 16'h03E8;
  localparam logic [31:0] FWIN_RST      = 32'h0000_0100;
  localparam logic [15:0] FTMO_RST      = 16'h000A;
  localparam logic [9:0]  STEPS_PER_PP  = 10'h004;
  localparam logic signed [32:0] TRQ_PERMILLE = 33'sh0_0000_03E8;
  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int          CLK_NS        = 100;
  localparam int          CYCLE_BASE_NS = 1000000;
  localparam int          MS_CYC        = CYCLE_BASE_NS / CLK_NS;
  localparam int          PULSE_MAX_HZ  = 1000000;
  localparam int          PULSE_ON_NS   = 200;
  localparam int          DIR_SETUP_NS  = 35000;
  localparam logic [5:0]  DIV_STEPS     = 6'h20;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_DIV  = 1'b1
  } csm_div_st_t;

  // true for both cyclic synchronous modes
  function automatic logic csm_is_cyclic(input logic [7:0] m);
    return (m == MODE_CSV) || (m == MODE_CST);
  endfunction : csm_is_cyclic

  // motion toward an active limit switch is refused
  function automatic logic csm_lim_hit(input logic neg, input logic nz,
                                       input logic ln, input logic lp);
    return neg ? ln : (nz && lp);
  endfunction : csm_lim_hit
endpackage : csm_pkg

// ===== src/csm_ferr_timer.sv
`timescale 1ns/10ps
`default_nettype none
module csm_ferr_timer
  import csm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        en,
  input  wire logic        over,
  input  wire logic        tick,
  input  wire logic [15:0] tmo,
  output logic             flag
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        flag;
  } csm_fe_t;

  csm_fe_t st, nx;

  // ----------------------------------------------------------
  // count whole ms spent outside the window
  // ----------------------------------------------------------
  always_comb begin
    nx = st;
    if (!en || !over) begin
      nx.cnt  = 16'h0000;
      nx.flag = 1'b0;
    end else begin
      if (tick && st.cnt != 16'hFFFF) begin
        nx.cnt = st.cnt + 16'h0001; // saturates, never wraps
      end
      nx.flag = st.cnt > tmo;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  assign flag = st.flag;

  a_ferr_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (!en || !over) |=> !flag) else $error("following error not cleared");
endmodule : csm_ferr_timer
`default_nettype wire

// ===== src/csm_mode_core.sv
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module csm_mode_core
  import csm_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        step_clk_in,
  input  wire logic        step_dir_in,
  input  wire logic        lim_neg_in,
  input  wire logic        lim_pos_in,
  input  wire logic [31:0] act_pos,
  output logic [31:0]      vel_cmd,
  output logic [15:0]      trq_cmd,
  output logic [31:0]      pos_dmd,
  output logic [15:0]      status_word
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [15:0] ctrl;
    logic        sub;
    logic        cl;
    logic [7:0]  pp;
    logic [7:0]  period;
    logic [7:0]  tidx;
    logic [31:0] tvel;
    logic [15:0] ttrq;
    logic [15:0] mtrq;
    logic [15:0] num;
    logic [15:0] den;
    logic [31:0] fwin;
    logic [15:0] ftmo;
    logic [15:0] ms_cnt;
    logic        ms_tick;
    logic [7:0]  cyc_cnt;
    logic        wrote;
    logic        sync;
    logic        follow;
    logic [47:0] pos;
    logic [31:0] wfx;
    csm_div_st_t dst;
    logic        div_req;
    logic [31:0] dvd;
    logic [16:0] rem;
    logic [31:0] quo;
    logic [5:0]  dcnt;
    logic [31:0] vel_cmd;
    logic [15:0] trq_cmd;
    logic [15:0] stat;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } csm_core_t;

  csm_core_t          st, nx;
  logic               clk_rise, dir_lvl, dir_rise;
  logic               lim_n, lim_p, ferr;
  logic               fe_over;
  logic signed [32:0] trq_prod;
  logic signed [32:0] pos_diff;
  logic [32:0]        pos_abs;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  csm_sync_edge u_clk (.pclk(pclk), .presetn(presetn), .pin(step_clk_in),
                       .lvl(), .rise(clk_rise));
  csm_sync_edge u_dir (.pclk(pclk), .presetn(presetn), .pin(step_dir_in),
                       .lvl(dir_lvl), .rise(dir_rise));
  csm_sync_edge u_lmn (.pclk(pclk), .presetn(presetn), .pin(lim_neg_in),
                       .lvl(lim_n), .rise());
  csm_sync_edge u_lmp (.pclk(pclk), .presetn(presetn), .pin(lim_pos_in),
                       .lvl(lim_p), .rise());

  // ----------------------------------------------------------
  // following error supervision
  // ----------------------------------------------------------
  assign pos_diff = $signed({st.pos[47], st.pos[47:16]}) - $signed({act_pos[31], act_pos});
  assign pos_abs  = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
  assign fe_over  = pos_abs > {1'b0, st.fwin};
  // torque scaled in per mille of the maximum
  assign trq_prod = $signed({{17{st.ttrq[15]}}, st.ttrq}) * $signed({17'h0_0000, st.mtrq});

  csm_ferr_timer u_fe (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (st.mode == MODE_STEP && st.cl),
    .over    (fe_over),
    .tick    (st.ms_tick),
    .tmo     (st.ftmo),
    .flag    (ferr)
  );

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  logic acc, wr, tgt_wr, cyc_end, cyc_ok, up, dn, qb;
  logic [16:0] r;
  logic [15:0] den_e;
  always_comb begin
    nx      = st;
    acc     = psel && penable && st.pready;
    wr      = acc && pwrite;
    up      = 1'b0;
    dn      = 1'b0;
    qb      = 1'b0;
    r       = 17'h0_0000;
    den_e   = (st.den == 16'h0000) ? 16'h0001 : st.den; // a zero divisor is treated as one
    nx.pready  = 1'b0;
    nx.pslverr = 1'b0;
    nx.ms_tick = 1'b0;
    // apb: one wait state, data and error registered with pready
    if (psel && penable && !st.pready) begin
      nx.pready  = 1'b1;
      nx.pslverr = 1'b0;
      case (paddr)
        A_MODE:   nx.prdata = {24'h00_0000, st.mode};
        A_CTRL:   nx.prdata = {16'h0000, st.ctrl};
        A_CFG:    nx.prdata = {16'h0000, st.pp, 6'h00, st.cl, st.sub};
        A_PERIOD: nx.prdata = {16'h0000, st.tidx, st.period};
        A_TVEL:   nx.prdata = st.tvel;
        A_TTRQ:   nx.prdata = {16'h0000, st.ttrq};
        A_MTRQ:   nx.prdata = {16'h0000, st.mtrq};
        A_NUM:    nx.prdata = {16'h0000, st.num};
        A_DEN:    nx.prdata = {16'h0000, st.den};
        A_FWIN:   nx.prdata = st.fwin;
        A_FTMO:   nx.prdata = {16'h0000, st.ftmo};
        A_STAT:   nx.prdata = {16'h0000, st.stat};
        A_POS:    nx.prdata = st.pos[47:16];
        A_REV:    nx.prdata = {22'h00_0000, 10'(st.pp) * STEPS_PER_PP};
        default: begin
          nx.prdata  = 32'h0000_0000;
          nx.pslverr = 1'b1;
        end
      endcase
    end
    // register writes take effect on the completing edge
    if (wr) begin
      case (paddr)
        A_MODE:   nx.mode = pwdata[7:0];
        A_CTRL:   nx.ctrl = pwdata[15:0]; // stored only
        A_CFG: begin
          nx.sub = pwdata[CFG_SUB];
          nx.cl  = pwdata[CFG_CL];
          nx.pp  = pwdata[CFG_PP_LSB +: 8];
        end
        A_PERIOD: begin
          nx.period = pwdata[7:0];
          nx.tidx   = pwdata[15:8];
        end
        A_TVEL:   nx.tvel = pwdata;
        A_TTRQ:   nx.ttrq = pwdata[15:0];
        A_MTRQ:   nx.mtrq = pwdata[15:0];
        A_NUM: begin
          nx.num     = pwdata[15:0];
          nx.div_req = 1'b1;
        end
        A_DEN: begin
          nx.den     = pwdata[15:0];
          nx.div_req = 1'b1;
        end
        A_FWIN:   nx.fwin = pwdata;
        A_FTMO:   nx.ftmo = pwdata[15:0];
        default:  nx.mode = st.mode;
      endcase
    end
    // millisecond base; cycle = period x 1 ms, index -3 only
    if (st.ms_cnt == 16'(MS_CYCLES - 1)) begin
      nx.ms_cnt  = 16'h0000;
      nx.ms_tick = 1'b1;
    end else begin
      nx.ms_cnt = st.ms_cnt + 16'h0001;
    end
    cyc_ok  = csm_is_cyclic(st.mode) && st.tidx == TIDX_MS && st.period != 8'h00;
    cyc_end = st.ms_tick && (st.cyc_cnt + 8'h01 >= st.period);
    if (st.ms_tick) begin
      nx.cyc_cnt = cyc_end ? 8'h00 : st.cyc_cnt + 8'h01;
    end
    tgt_wr = wr && ((paddr == A_TVEL && st.mode == MODE_CSV) ||
                    (paddr == A_TTRQ && st.mode == MODE_CST));
    // a write landing on the cycle edge still counts for that cycle
    if (cyc_end) begin
      nx.sync  = st.wrote || tgt_wr;
      nx.wrote = 1'b0;
    end else if (tgt_wr) begin
      nx.wrote = 1'b1;
    end
    if (!cyc_ok) begin
      nx.sync  = 1'b0;
      nx.wrote = 1'b0;
    end
    // target is used only in sync; torque also needs closed loop
    nx.follow = csm_is_cyclic(st.mode) && st.sync &&
                (st.mode != MODE_CST || st.cl);
    // velocity setpoint passes straight through, torque is scaled; no ramp generator
    nx.vel_cmd = 32'h0000_0000;
    nx.trq_cmd = 16'h0000;
    if (st.follow && st.mode == MODE_CSV &&
        !csm_lim_hit(st.tvel[31], st.tvel != 32'h0, lim_n, lim_p)) begin
      nx.vel_cmd = st.tvel;
    end
    if (st.follow && st.mode == MODE_CST &&
        !csm_lim_hit(st.ttrq[15], st.ttrq != 16'h0, lim_n, lim_p)) begin
      nx.trq_cmd = 16'(trq_prod / TRQ_PERMILLE);
    end
    // step/direction decode; both edges together cancel out
    if (st.sub) begin
      up = clk_rise;
      dn = dir_rise;
    end else begin
      up = clk_rise && dir_lvl;
      dn = clk_rise && !dir_lvl;
    end
    if (st.mode == MODE_STEP) begin
      if (up && !dn && !csm_lim_hit(1'b0, 1'b1, lim_n, lim_p)) begin
        nx.pos = st.pos + {16'h0000, st.wfx};
      end else if (dn && !up && !csm_lim_hit(1'b1, 1'b1, lim_n, lim_p)) begin
        nx.pos = st.pos - {16'h0000, st.wfx};
      end
    end
    // width = num/den in 16.16, old width used until done
    case (st.dst)
      ST_IDLE: begin
        if (st.div_req && !wr) begin
          nx.div_req = 1'b0;
          nx.dst     = ST_DIV;
          nx.dvd     = {st.num, 16'h0000};
          nx.rem     = 17'h0_0000;
          nx.quo     = 32'h0000_0000;
          nx.dcnt    = DIV_STEPS;
        end
      end
      ST_DIV: begin
        r  = {st.rem[15:0], st.dvd[31]};
        qb = r >= {1'b0, den_e};
        nx.rem  = qb ? r - {1'b0, den_e} : r;
        nx.dvd  = {st.dvd[30:0], 1'b0};
        nx.quo  = {st.quo[30:0], qb};
        nx.dcnt = st.dcnt - 6'h01;
        if (st.dcnt == 6'h01) begin
          nx.wfx = {st.quo[30:0], qb};
          nx.dst = ST_IDLE;
        end
      end
      default: nx.dst = ST_IDLE;
    endcase
    nx.stat             = 16'h0000;
    nx.stat[SW_SYNC]    = st.sync;
    nx.stat[SW_FOLLOW]  = st.follow;
    nx.stat[SW_FERR]    = ferr;
    nx.stat[SW_LIM_NEG] = lim_n;
    nx.stat[SW_LIM_POS] = lim_p;
  end

  // ----------------------------------------------------------
  // state register
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.num    <= NUM_RST;
      st.den    <= DEN_RST;
      st.wfx    <= WFX_RST;
      st.period <= PERIOD_RST;
      st.tidx   <= TIDX_RST;
      st.pp     <= PP_RST;
      st.mtrq   <= MTRQ_RST;
      st.fwin   <= FWIN_RST;
      st.ftmo   <= FTMO_RST;
      st.dst    <= ST_IDLE;
    end else begin
      st <= nx;
    end
  end

  assign prdata      = st.prdata;
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign vel_cmd     = st.vel_cmd;
  assign trq_cmd     = st.trq_cmd;
  assign pos_dmd     = st.pos[47:16];
  assign status_word = st.stat;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cycle_miss;
    cyc_end && !st.wrote && !tgt_wr;
  endsequence
  sequence s_step_up;
    st.mode == MODE_STEP && up && !dn && !lim_p && st.dst == ST_IDLE;
  endsequence

  a_vel_follow: assert property (
    (st.follow && st.mode == MODE_CSV && !lim_n && !lim_p) |=> vel_cmd == $past(st.tvel))
    else $error("velocity setpoint not passed through");
  a_trq_openloop: assert property (
    (st.mode == MODE_CST && !st.cl) |=> (!st.follow ##1 trq_cmd == 16'h0000))
    else $error("torque applied without closed loop");
  a_trq_sel: assert property (
    (st.mode != MODE_CST) |=> trq_cmd == 16'h0000)
    else $error("torque output outside torque mode");
  a_step_gate: assert property (
    (st.mode != MODE_STEP) |=> $stable(st.pos))
    else $error("position moved outside step mode");
  a_sync_drop: assert property (
    s_cycle_miss |=> ##1 !status_word[SW_SYNC])
    else $error("sync kept after a missed cycle");
  a_follow_sync: assert property (
    st.follow |-> $past(st.sync))
    else $error("target used without sync");
  a_step_move: assert property (
    s_step_up |=> st.pos == $past(st.pos) + {16'h0000, $past(st.wfx)})
    else $error("step did not add one width");
  a_div_span: assert property (
    $rose(st.dst == ST_DIV) |-> ##32 st.dst == ST_IDLE)
    else $error("width division not 32 cycles");
  a_ctrl_inert: assert property (
    (wr && paddr == A_CTRL && !st.ms_tick) |=> $stable(st.sync))
    else $error("control word changed behaviour");
endmodule : csm_mode_core
`default_nettype wire

// ===== src/csm_sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
module csm_sync_edge
  import csm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      lvl,
  output logic      rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } csm_se_t;

  csm_se_t st, nx;

  // ----------------------------------------------------------
  // two-stage synchroniser plus history for edge detection
  // ----------------------------------------------------------
  always_comb begin
    nx    = st;
    nx.s1 = pin;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nx;
    end
  end

  // s1 is only ever read by s2, never by the edge logic
  assign lvl  = st.s2;
  assign rise = st.s2 && !st.s3;

  a_rise_single: assert property (@(posedge pclk) disable iff (!presetn)
    rise |=> !rise) else $error("edge pulse longer than one cycle");
endmodule : csm_sync_edge
`default_nettype wire

// ===== verification/csm_step_host.sv
`timescale 1ns/10ps
`default_nettype none
// pulse source standing in for the motion controller on the step pins
module csm_step_host
  import csm_pkg::*;
#(
  parameter int HI_CYC  = 4,
  parameter int LO_CYC  = 6,
  parameter int DIR_CYC = 360
) (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic       neg,
  input  wire logic       dual,
  input  wire logic [7:0] n,
  output logic            clk_pin,
  output logic            dir_pin,
  output logic            busy
);
  // one burst per go; clock pin idles low between bursts, direction pin holds its level
  initial begin
    clk_pin = 1'b0;
    dir_pin = 1'b0;
    busy    = 1'b0;
    forever begin
      @(posedge pclk);
      if (go) begin
        busy <= 1'b1;
        if (dual) begin
          dir_pin <= 1'b0;
          @(posedge pclk);
        end else if (dir_pin !== !neg) begin
          dir_pin <= !neg; // high means positive
          repeat (DIR_CYC) @(posedge pclk); // settle before next pulse
        end
        repeat (n) begin
          if (dual && neg) dir_pin <= 1'b1; // pin used picks direction
          else clk_pin <= 1'b1;
          repeat (HI_CYC) @(posedge pclk); // 400 ns high
          clk_pin <= 1'b0;
          if (dual) dir_pin <= 1'b0;
          repeat (LO_CYC) @(posedge pclk); // 1 us period is the fastest allowed
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : csm_step_host
`default_nettype wire

// ===== verification/tb_csm_mode_core.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, x, g) begin n_checks++; if ((g) !== (x)) begin err_total++; $display("MISMATCH %s exp %0h got %0h", nm, x, g); end end
module tb_csm_mode_core
  import csm_pkg::*;
;
  localparam int MSC   = 20;
  localparam int LIMIT = 20000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        step_clk_in, step_dir_in, lim_neg_in, lim_pos_in, go, neg, dual, busy;
  logic [7:0]  paddr, n;
  logic [31:0] pwdata, prdata, act_pos, vel_cmd, pos_dmd, q;
  logic [15:0] trq_cmd, status_word;
  int          err_total, n_checks;
  int          cyc = 0;
  logic [7:0]  ra [9] = '{A_MODE, A_CFG, A_PERIOD, A_NUM, A_DEN, A_MTRQ, A_FWIN, A_FTMO, A_REV};
  logic [31:0] rv [9] = '{32'h0, 32'h100, 32'hFD01, 32'h80, 32'h1, 32'h3E8, 32'h100, 32'hA, 32'h4};

  csm_mode_core #(.MS_CYCLES(MSC)) u_csm_mode_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .step_clk_in(step_clk_in), .step_dir_in(step_dir_in), .lim_neg_in(lim_neg_in),
    .lim_pos_in(lim_pos_in), .act_pos(act_pos), .vel_cmd(vel_cmd), .trq_cmd(trq_cmd), .pos_dmd(pos_dmd),
    .status_word(status_word));
  csm_step_host u_csm_step_host (.pclk(pclk), .go(go), .neg(neg), .dual(dual), .n(n),
    .clk_pin(step_clk_in), .dir_pin(step_dir_in), .busy(busy));

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      complete_run();
    end
  end
  // ----------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // request held until pready is seen at an edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, q)
  endtask : rd
  // five writes per ms keeps every cycle supplied
  task feed(input logic [7:0] a, input logic [31:0] d, input int ms);
    repeat (ms * MSC / 4) wr(a, d);
  endtask : feed
  task ms_wait(input int m);
    repeat (m * MSC) @(posedge pclk);
  endtask : ms_wait
  task step(input logic ng, input logic du, input logic [7:0] k);
    @(posedge pclk);
    go <= 1'b1;
    neg <= ng;
    dual <= du;
    n <= k;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
    repeat (8) @(posedge pclk);
  endtask : step
  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, lim_neg_in, lim_pos_in, go, neg, dual} = 8'h00;
    paddr = 8'h00;
    n = 8'h00;
    pwdata = 32'h0;
    act_pos = 32'h0;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i], "reset value");
    wr(A_REV, 32'h7);
    rd(A_REV, 32'h4, "read-only");
    apb(1'b0, 8'h38, 32'h0);
    `CHK("unmapped", 1'b1, e)
    $display("test registers done");
    // velocity mode, control word must not matter
    wr(A_MODE, 32'h09);
    wr(A_CTRL, 32'hFFFF);
    feed(A_TVEL, 32'h1234, 4);
    `CHK("sync", 1'b1, status_word[SW_SYNC])
    `CHK("follow", 1'b1, status_word[SW_FOLLOW])
    `CHK("vel", 32'h1234, vel_cmd)
    feed(A_TVEL, 32'hFFFF_F000, 2);
    `CHK("vel step", 32'hFFFF_F000, vel_cmd)
    ms_wait(3);
    `CHK("sync lost", 1'b0, status_word[SW_SYNC])
    `CHK("follow lost", 1'b0, status_word[SW_FOLLOW])
    `CHK("vel idle", 32'h0, vel_cmd)
    wr(A_PERIOD, 32'hFE01);
    feed(A_TVEL, 32'h1234, 3);
    `CHK("bad index", 1'b0, status_word[SW_SYNC])
    wr(A_PERIOD, 32'hFD02);
    // writes 1.7 ms apart only satisfy a 2 ms cycle
    for (int i = 0; i < 8; i++) begin
      wr(A_TVEL, 32'h1234);
      repeat (30) @(posedge pclk);
      if (i > 3) `CHK("sync 2ms", 1'b1, status_word[SW_SYNC])
    end
    wr(A_PERIOD, 32'hFD01);
    $display("test velocity done");
    // torque mode, open loop first
    wr(A_MODE, 32'h0A);
    feed(A_TTRQ, 32'h01F4, 3);
    `CHK("trq open", 16'h0000, trq_cmd)
    `CHK("no follow", 1'b0, status_word[SW_FOLLOW])
    `CHK("vel in trq", 32'h0, vel_cmd)
    wr(A_CFG, 32'h0102);
    wr(A_MTRQ, 32'h07D0);
    feed(A_TTRQ, 32'h01F4, 4);
    `CHK("trq", 16'h03E8, trq_cmd)
    `CHK("trq follow", 1'b1, status_word[SW_FOLLOW])
    $display("test torque done");
    // step and direction
    wr(A_MODE, 32'hFF);
    wr(A_CFG, 32'h0100);
    step(1'b0, 1'b0, 8'h04);
    `CHK("pos quarter", 32'h200, pos_dmd)
    wr(A_NUM, 32'h200);
    wr(A_DEN, 32'h3);
    repeat (40) @(posedge pclk);
    step(1'b1, 1'b0, 8'h03);
    `CHK("pos frac", 32'h0, pos_dmd)
    lim_pos_in <= 1'b1;
    step(1'b0, 1'b0, 8'h02);
    `CHK("pos limit", 32'h0, pos_dmd)
    `CHK("lim pos flag", 1'b1, status_word[SW_LIM_POS])
    lim_pos_in <= 1'b0;
    wr(A_CFG, 32'h0101);
    step(1'b0, 1'b1, 8'h02);
    `CHK("pos dual up", 32'h155, pos_dmd)
    step(1'b1, 1'b1, 8'h01);
    `CHK("pos dual dn", 32'hAA, pos_dmd)
    lim_neg_in <= 1'b1;
    step(1'b1, 1'b1, 8'h01);
    `CHK("pos neg limit", 32'hAA, pos_dmd)
    `CHK("lim neg flag", 1'b1, status_word[SW_LIM_NEG])
    lim_neg_in <= 1'b0;
    wr(A_FTMO, 32'h2);
    wr(A_CFG, 32'h0303);
    act_pos <= 32'hFFFF_FF00;
    ms_wait(1);
    `CHK("ferr early", 1'b0, status_word[SW_FERR])
    ms_wait(3);
    `CHK("ferr", 1'b1, status_word[SW_FERR])
    act_pos <= 32'hAA;
    repeat (5) @(posedge pclk);
    `CHK("ferr clear", 1'b0, status_word[SW_FERR])
    rd(A_REV, 32'hC, "rev");
    $display("test step done");
    complete_run();
  end
endmodule : tb_csm_mode_core
`default_nettype wire
